// file: rtl/pfa_pkg.sv
/*
 package for the asynchronous packet fifo host access block: register offsets,
 status and flag bit positions, fifo depths, acknowledge codes and the beat struct.
 assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none
package pfa_pkg;
	// ----------------------------------------------------------------
	// register byte offsets (byte-wide host port, 8 bit address)
	// ----------------------------------------------------------------
	localparam logic [7:0] PFA_OFF_IRQ_FLAGS = 8'h0C; // async_interrupt_flags
	localparam logic [7:0] PFA_OFF_IRQ_MASK = 8'h10; // async_interrupt_mask
	localparam logic [7:0] PFA_OFF_STATUS = 8'h1C; // async_fifo_status
	localparam logic [7:0] PFA_OFF_TX_FIRST = 8'h70; // first quadlet port
	localparam logic [7:0] PFA_OFF_TX_MID = 8'h74; // tx_middle_rx_read_port
	localparam logic [7:0] PFA_OFF_TX_COMMIT = 8'h7C; // commit port
	// ----------------------------------------------------------------
	// flag register bits
	// ----------------------------------------------------------------
	localparam int PFA_BIT_RX_PKT = 25; // rx_packet_flag
	localparam int PFA_BIT_MISPLACED = 18; // misplaced_start_flag
	localparam int PFA_BIT_TCODE_ERR = 17; // tx_code_error_flag
	// ----------------------------------------------------------------
	// status register bits
	// ----------------------------------------------------------------
	localparam int PFA_BIT_RX_FULL = 31;
	localparam int PFA_BIT_RX_AFULL = 30;
	localparam int PFA_BIT_RX_FOUR = 29; // rx_four_available_flag
	localparam int PFA_BIT_RX_BOUND = 28; // rx_packet_boundary_flag
	localparam int PFA_BIT_RX_AEMPTY = 27; // rx_almost_empty_flag
	localparam int PFA_BIT_RX_EMPTY = 26; // rx_fifo_empty_flag
	localparam int PFA_BIT_TX_FULL = 23; // tx_fifo_full_flag
	localparam int PFA_BIT_TX_AFULL = 22;
	localparam int PFA_BIT_TX_FOUR = 21;
	localparam int PFA_BIT_TX_AEMPTY = 20;
	localparam int PFA_BIT_TX_EMPTY = 19;
	localparam int PFA_BIT_TX_FLUSH = 15; // tx_fifo_flush_bit, self clearing
	// ----------------------------------------------------------------
	// fifo geometry and codes
	// ----------------------------------------------------------------
	localparam int PFA_TX_DEPTH = 24;
	localparam int PFA_RX_DEPTH = 39;
	localparam logic [15:0] PFA_TCODE_OK = 16'h4AF7; // one bit per legal tCode
	localparam logic [3:0] PFA_ACK_OVERFLOW = 4'h4;
	localparam logic [3:0] PFA_ACK_DATA_ERR = 4'hD;
	localparam logic [5:0] PFA_NODE_BCAST = 6'h3F;
	localparam logic [31:0] PFA_RESET_WORD = 32'h0000_0000;
	// one fifo entry: packet markers plus the quadlet
	typedef struct packed {
		logic last;
		logic first;
		logic [31:0] data;
	} pfa_beat_s;
	// receive sequencer states
	typedef enum logic [1:0] {
		PFA_RX_IDLE = 2'b00,
		PFA_RX_RECV = 2'b01,
		PFA_RX_DROP = 2'b10,
		PFA_RX_TRAIL = 2'b11
	} pfa_rx_e;
endpackage
`default_nettype wire

// file: rtl/pfa_qmem.sv
/*
 small two-port quadlet memory used for both packet fifos.
 assumes one clock; read data come from a register one edge after the address.
*/
`default_nettype none
module pfa_qmem
	import pfa_pkg::*;
#(
	parameter int DEPTH = 24,
	parameter int AW = 5
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire pfa_beat_s wdata,
	input wire logic [AW-1:0] raddr,
	output pfa_beat_s rdata_q
);
	pfa_beat_s mem [DEPTH]; // storage, no reset needed

	// write port
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// registered read port; a same-edge write shows one edge later
	always_ff @(posedge clk) begin
		rdata_q <= mem[raddr];
	end
endmodule
`default_nettype wire

// file: rtl/pfa_async_fifo_host.sv
/*
 host access to the asynchronous transmit and receive packet fifos.
 assumes the host strobes and the link stream run on clk, host strobes
 are one cycle wide and at least two cycles apart.
*/
// Function
// - committed packet sends itself when bus enabled
// - flag start written to wrong port
// - flag illegal tCode in first quadlet
// - legal codes 0,1,2,4,5,6,7,9,B,E
// - errors hold transmit until fifo flush
// - receive only with room and matching node
// - set bit 25, masked onto low interrupt
// - read pops; empty read repeats last value
// - boundary flag marks head first quadlet
// - four available flag at four quadlets
// - almost empty flag at exactly one
// - append trailer carrying sent ack code
// - trailer ack 04h on receive overflow
// - trailer ack 0Dh on crc error
// - writes ignored while transmit fifo full
`default_nettype none
module pfa_async_fifo_host
	import pfa_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] host_addr,
	input wire logic [7:0] host_wdata,
	input wire logic host_wr,
	input wire logic host_rd,
	output logic [7:0] host_rdata_q,
	output logic interrupt_out_n,
	input wire logic bus_enable,
	input wire logic [15:0] node_id,
	output logic tx_valid,
	input wire logic tx_ready,
	output pfa_beat_s tx_beat,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire pfa_beat_s rx_beat,
	input wire logic [3:0] rx_ack,
	input wire logic rx_crc_err
);
	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// word match on the upper address bits; lane comes from addr[1:0]
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction

	logic [1:0] lane; // byte lane of this access
	logic [23:0] stage_q; // lower bytes of a quadlet being written
	logic [31:0] quad; // completed quadlet on the top-lane write
	logic q_ev, first_ev, mid_ev, last_ev; // quadlet write events per port
	assign lane = host_addr[1:0];
	assign quad = {host_wdata, stage_q};
	assign q_ev = host_wr && (lane == 2'd3);
	assign first_ev = q_ev && hit(host_addr, PFA_OFF_TX_FIRST);
	assign mid_ev = q_ev && hit(host_addr, PFA_OFF_TX_MID);
	assign last_ev = q_ev && hit(host_addr, PFA_OFF_TX_COMMIT);

	// lower lanes are staged; the top lane completes the quadlet
	for (genvar g = 0; g < 3; g++) begin : g_stage
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				stage_q[g*8 +: 8] <= 8'h00;
			end else if (host_wr && lane == 2'(g)) begin
				stage_q[g*8 +: 8] <= host_wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// transmit fifo
	// ----------------------------------------------------------------
	logic [4:0] tx_wp_q, tx_rp_q; // write and read pointers
	logic [4:0] tx_cnt_q, tx_com_q, tx_vis_q; // stored, committed, visible
	logic [4:0] tx_len_q; // quadlets of the open packet
	logic in_pkt_q, tx_hold_q, tx_pop_q;
	logic tx_full, tx_push, tx_pop, tx_flush, tcode_bad;
	pfa_beat_s tx_wbeat;
	assign tx_full = (tx_cnt_q == 5'(PFA_TX_DEPTH));
	assign tcode_bad = !PFA_TCODE_OK[quad[7:4]];
	assign tx_flush = host_wr && hit(host_addr, PFA_OFF_STATUS) && lane == 2'd1
		&& host_wdata[PFA_BIT_TX_FLUSH-8];
	// a full fifo swallows the write silently
	assign tx_push = !tx_full && (first_ev || ((mid_ev || last_ev) && in_pkt_q));
	assign tx_wbeat = '{last: last_ev, first: first_ev, data: quad};
	// the pop of the previous cycle still shows old read data, so skip a cycle
	assign tx_valid = bus_enable && !tx_hold_q && tx_vis_q != 5'd0 && !tx_pop_q;
	assign tx_pop = tx_valid && tx_ready;

	// pointers and counts; flush wins over everything
	always_ff @(posedge clk) begin
		if (!rst_n || tx_flush) begin
			tx_wp_q <= 5'd0;
			tx_rp_q <= 5'd0;
			tx_cnt_q <= 5'd0;
			tx_com_q <= 5'd0;
			tx_vis_q <= 5'd0;
			tx_len_q <= 5'd0;
			tx_pop_q <= 1'b0;
		end else begin
			tx_pop_q <= tx_pop;
			tx_vis_q <= tx_com_q;
			if (tx_push) begin
				tx_wp_q <= (tx_wp_q == 5'(PFA_TX_DEPTH - 1)) ? 5'd0 : tx_wp_q + 5'd1;
			end
			if (tx_pop) begin
				tx_rp_q <= (tx_rp_q == 5'(PFA_TX_DEPTH - 1)) ? 5'd0 : tx_rp_q + 5'd1;
			end
			tx_cnt_q <= tx_cnt_q + 5'(tx_push) - 5'(tx_pop);
			// commit makes the whole packet eligible at once
			if (tx_push && last_ev) begin
				tx_com_q <= tx_com_q + tx_len_q + 5'd1 - 5'(tx_pop);
				tx_len_q <= 5'd0;
			end else begin
				tx_com_q <= tx_com_q - 5'(tx_pop);
				tx_len_q <= first_ev ? 5'(tx_push) : tx_len_q + 5'(tx_push);
			end
		end
	end

	// packet framing and the hold that follows any framing error
	always_ff @(posedge clk) begin
		if (!rst_n || tx_flush) begin
			in_pkt_q <= 1'b0;
			tx_hold_q <= 1'b0;
		end else begin
			if (first_ev) begin
				in_pkt_q <= 1'b1;
			end else if (last_ev) begin
				in_pkt_q <= 1'b0;
			end
			if ((first_ev && tcode_bad) || ((mid_ev || last_ev) && !in_pkt_q)) begin
				tx_hold_q <= 1'b1;
			end
		end
	end

	pfa_qmem #(.DEPTH(PFA_TX_DEPTH), .AW(5)) u_tx_mem (
		.clk(clk),
		.we(tx_push),
		.waddr(tx_wp_q),
		.wdata(tx_wbeat),
		.raddr(tx_rp_q),
		.rdata_q(tx_beat)
	);

	// ----------------------------------------------------------------
	// receive sequencer and fifo
	// ----------------------------------------------------------------
	pfa_rx_e rx_state_q;
	logic [5:0] rx_wp_q, rx_rp_q, rx_cnt_q, rx_vis_q;
	logic rx_ovf_q, rx_err_q, rx_push, rx_pop, dest_ok, room_ok;
	pfa_beat_s rx_wbeat, rx_head;
	logic [31:0] rx_prev_q; // last quadlet handed to the host
	logic [3:0] ack_code;
	// broadcast node number is accepted when the bus number matches
	assign dest_ok = rx_beat.data[31:22] == node_id[15:6]
		&& (rx_beat.data[21:16] == node_id[5:0] || rx_beat.data[21:16] == PFA_NODE_BCAST);
	// one slot is always kept back for the trailer
	assign room_ok = rx_cnt_q < 6'(PFA_RX_DEPTH - 1);
	assign rx_ready = (rx_state_q != PFA_RX_TRAIL);
	assign ack_code = rx_ovf_q ? PFA_ACK_OVERFLOW : (rx_err_q ? PFA_ACK_DATA_ERR : rx_ack);
	always_comb begin
		rx_push = 1'b0;
		rx_wbeat = rx_beat;
		case (rx_state_q)
			PFA_RX_IDLE: begin
				rx_push = rx_valid && rx_beat.first && dest_ok && rx_cnt_q < 6'(PFA_RX_DEPTH - 2);
			end
			PFA_RX_RECV: begin
				rx_push = rx_valid && room_ok;
			end
			PFA_RX_TRAIL: begin
				rx_push = 1'b1;
				rx_wbeat = '{last: 1'b1, first: 1'b0, data: {28'h0, ack_code}};
			end
			default: begin
				rx_push = 1'b0;
			end
		endcase
	end

	// packet walk: accept, drop, or close with the trailer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_state_q <= PFA_RX_IDLE;
			rx_ovf_q <= 1'b0;
			rx_err_q <= 1'b0;
		end else begin
			case (rx_state_q)
				PFA_RX_IDLE: begin
					rx_ovf_q <= 1'b0;
					rx_err_q <= 1'b0;
					if (rx_valid && rx_beat.first) begin
						if (rx_push) begin
							rx_state_q <= rx_beat.last ? PFA_RX_TRAIL : PFA_RX_RECV;
							rx_err_q <= rx_beat.last && rx_crc_err;
						end else if (!rx_beat.last) begin
							rx_state_q <= PFA_RX_DROP;
						end
					end
				end
				PFA_RX_RECV: begin
					if (rx_valid) begin
						// quadlets beyond the room are lost, trailer says so
						if (!room_ok) begin
							rx_ovf_q <= 1'b1;
						end
						if (rx_beat.last) begin
							rx_err_q <= rx_crc_err;
							rx_state_q <= PFA_RX_TRAIL;
						end
					end
				end
				PFA_RX_DROP: begin
					if (rx_valid && rx_beat.last) begin
						rx_state_q <= PFA_RX_IDLE;
					end
				end
				PFA_RX_TRAIL: begin
					rx_state_q <= PFA_RX_IDLE;
				end
				default: begin
					rx_state_q <= PFA_RX_IDLE;
				end
			endcase
		end
	end

	// host pop on the low byte of the read port; an empty fifo is left alone
	assign rx_pop = host_rd && hit(host_addr, PFA_OFF_TX_MID) && lane == 2'd0
		&& rx_vis_q != 6'd0;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_wp_q <= 6'd0;
			rx_rp_q <= 6'd0;
			rx_cnt_q <= 6'd0;
			rx_vis_q <= 6'd0;
			rx_prev_q <= PFA_RESET_WORD;
		end else begin
			// visible count trails by one edge to match the registered read
			rx_vis_q <= rx_cnt_q;
			if (rx_push) begin
				rx_wp_q <= (rx_wp_q == 6'(PFA_RX_DEPTH - 1)) ? 6'd0 : rx_wp_q + 6'd1;
			end
			if (rx_pop) begin
				rx_rp_q <= (rx_rp_q == 6'(PFA_RX_DEPTH - 1)) ? 6'd0 : rx_rp_q + 6'd1;
				rx_prev_q <= rx_head.data;
			end
			rx_cnt_q <= rx_cnt_q + 6'(rx_push) - 6'(rx_pop);
		end
	end

	pfa_qmem #(.DEPTH(PFA_RX_DEPTH), .AW(6)) u_rx_mem (
		.clk(clk),
		.we(rx_push),
		.waddr(rx_wp_q),
		.wdata(rx_wbeat),
		.raddr(rx_rp_q),
		.rdata_q(rx_head)
	);

	// ----------------------------------------------------------------
	// flags, mask and interrupt
	// ----------------------------------------------------------------
	logic [31:0] flags_q, mask_q, status, rd_word, snap_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mask_q <= PFA_RESET_WORD;
		end else if (host_wr && hit(host_addr, PFA_OFF_IRQ_MASK)) begin
			mask_q[lane*8 +: 8] <= host_wdata;
		end
	end

	// write one to clear; a same-cycle event wins over the clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags_q <= PFA_RESET_WORD;
		end else begin
			if (host_wr && hit(host_addr, PFA_OFF_IRQ_FLAGS)) begin
				flags_q[lane*8 +: 8] <= flags_q[lane*8 +: 8] & ~host_wdata;
			end
			if (rx_state_q == PFA_RX_TRAIL) begin
				flags_q[PFA_BIT_RX_PKT] <= 1'b1;
			end
			if ((mid_ev || last_ev) && !in_pkt_q) begin
				flags_q[PFA_BIT_MISPLACED] <= 1'b1;
			end
			if (first_ev && tcode_bad) begin
				flags_q[PFA_BIT_TCODE_ERR] <= 1'b1;
			end
		end
	end
	assign interrupt_out_n = !(|(flags_q & mask_q));

	// ----------------------------------------------------------------
	// status and read path
	// ----------------------------------------------------------------
	always_comb begin
		status = PFA_RESET_WORD;
		status[PFA_BIT_RX_FULL] = rx_vis_q == 6'(PFA_RX_DEPTH);
		status[PFA_BIT_RX_AFULL] = rx_vis_q == 6'(PFA_RX_DEPTH - 1);
		status[PFA_BIT_RX_FOUR] = rx_vis_q >= 6'd4;
		status[PFA_BIT_RX_BOUND] = rx_vis_q != 6'd0 && rx_head.first;
		status[PFA_BIT_RX_AEMPTY] = rx_vis_q == 6'd1;
		status[PFA_BIT_RX_EMPTY] = rx_vis_q == 6'd0;
		status[PFA_BIT_TX_FULL] = tx_full;
		status[PFA_BIT_TX_AFULL] = tx_cnt_q == 5'(PFA_TX_DEPTH - 1);
		status[PFA_BIT_TX_FOUR] = tx_cnt_q <= 5'(PFA_TX_DEPTH - 4);
		status[PFA_BIT_TX_AEMPTY] = tx_cnt_q == 5'd1;
		status[PFA_BIT_TX_EMPTY] = tx_cnt_q == 5'd0;
		rd_word = PFA_RESET_WORD;
		if (hit(host_addr, PFA_OFF_IRQ_FLAGS)) begin
			rd_word = flags_q;
		end else if (hit(host_addr, PFA_OFF_IRQ_MASK)) begin
			rd_word = mask_q;
		end else if (hit(host_addr, PFA_OFF_STATUS)) begin
			rd_word = status;
		end else if (hit(host_addr, PFA_OFF_TX_MID)) begin
			rd_word = (rx_vis_q != 6'd0) ? rx_head.data : rx_prev_q;
		end
	end

	// byte 0 freezes the whole word so the upper bytes stay coherent
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			snap_q <= PFA_RESET_WORD;
			host_rdata_q <= 8'h00;
		end else if (host_rd) begin
			if (lane == 2'd0) begin
				snap_q <= rd_word;
				host_rdata_q <= rd_word[7:0];
			end else begin
				host_rdata_q <= snap_q[lane*8 +: 8];
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_rx_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
		rx_state_q == PFA_RX_TRAIL |=> flags_q[PFA_BIT_RX_PKT] && rx_state_q == PFA_RX_IDLE)
		else $error("receive flag not set after trailer");
	a_irq_drive: assert property (@(posedge clk) disable iff (!rst_n)
		rx_state_q == PFA_RX_TRAIL && mask_q[PFA_BIT_RX_PKT] |=> !interrupt_out_n)
		else $error("interrupt not driven low");
	a_misplaced_start: assert property (@(posedge clk) disable iff (!rst_n)
		(mid_ev || last_ev) && !in_pkt_q && !tx_flush |=> flags_q[PFA_BIT_MISPLACED] && tx_hold_q)
		else $error("misplaced start not flagged");
	a_tcode_check: assert property (@(posedge clk) disable iff (!rst_n)
		first_ev && !tx_flush && quad[7:4] == 4'h3 |=> flags_q[PFA_BIT_TCODE_ERR])
		else $error("illegal tcode not flagged");
	a_hold_blocks: assert property (@(posedge clk) disable iff (!rst_n)
		tx_hold_q && !tx_flush |=> tx_hold_q && !tx_valid)
		else $error("transmit while held");
	a_auto_send: assert property (@(posedge clk) disable iff (!rst_n)
		(bus_enable && !tx_hold_q && tx_com_q != 5'd0 && !tx_ready && !tx_flush)[*3] |-> tx_valid)
		else $error("committed packet not offered");
	a_full_ignore: assert property (@(posedge clk) disable iff (!rst_n)
		tx_full && q_ev && !tx_pop && !tx_flush |=> tx_cnt_q == 5'(PFA_TX_DEPTH))
		else $error("write stored into full fifo");
	a_empty_read: assert property (@(posedge clk) disable iff (!rst_n)
		host_rd && hit(host_addr, PFA_OFF_TX_MID) && lane == 2'd0 && rx_vis_q == 6'd0
		|=> host_rdata_q == $past(rx_prev_q[7:0]) && $stable(rx_rp_q))
		else $error("empty read changed fifo");
	a_ovf_ack: assert property (@(posedge clk) disable iff (!rst_n)
		rx_state_q == PFA_RX_TRAIL && rx_ovf_q |-> rx_push && rx_wbeat.data[3:0] == 4'h4)
		else $error("overflow ack missing");
	a_crc_ack: assert property (@(posedge clk) disable iff (!rst_n)
		rx_state_q == PFA_RX_TRAIL && !rx_ovf_q && rx_err_q |-> rx_wbeat.data[3:0] == 4'hD)
		else $error("data error ack missing");
	a_rx_reject: assert property (@(posedge clk) disable iff (!rst_n)
		rx_state_q == PFA_RX_IDLE && rx_valid && rx_beat.first && !dest_ok |-> !rx_push)
		else $error("foreign packet accepted");
endmodule
`default_nettype wire

// file: verif/pfa_link_model.sv
/*
 link side model: takes transmit beats, stalling on request, and sends
 receive packets beat by beat.
 assumes the device on clk, with inputs changed at the falling edge.
*/
`default_nettype none
module pfa_link_model
	import pfa_pkg::*;
(
	input wire logic clk,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire pfa_beat_s tx_beat,
	output logic rx_valid,
	input wire logic rx_ready,
	output pfa_beat_s rx_beat,
	output logic [3:0] rx_ack,
	output logic rx_crc_err
);
	timeunit 1ns;
	timeprecision 1ps;
	pfa_beat_s got[$]; // every beat the link took
	logic slow = 1'b0; // set: ready only half the time
	logic [2:0] cnt = 3'h0; // stall pattern counter
	int stuck = 0; // receive ready waits that ran out
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_beat = '0;
		rx_ack = 4'h0;
		rx_crc_err = 1'b0;
	end
	// a slow link stalls in runs of four, so an offer must stand through a long stall
	always @(negedge clk) begin
		cnt <= cnt + 3'h1;
		tx_ready <= slow ? cnt[2] : 1'b1;
	end
	// record a beat at the edge that takes it
	always @(posedge clk) begin
		if (tx_valid && tx_ready)
			got.push_back(tx_beat);
	end
	// one packet; the ack stays up through the trailer cycle
	task automatic send(input logic [31:0] w[$], input logic [3:0] ack, input logic crc);
		rx_ack = ack;
		foreach (w[i]) begin
			@(negedge clk);
			// bounded: ready is low for one trailer cycle only
			for (int k = 0; k < 50 && !rx_ready; k++) @(negedge clk);
			if (!rx_ready) stuck++;
			rx_valid = 1'b1;
			rx_beat = '{last: i == w.size() - 1, first: i == 0, data: w[i]};
			rx_crc_err = crc && (i == w.size() - 1);
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_crc_err = 1'b0;
		// released lines must not keep the last value
		rx_beat = ~rx_beat;
		repeat (2) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// file: verif/tb_pfa_async_fifo_host.sv
/*
 self-checking bench for the packet fifo host access block.
 assumes the link model beside it; host bytes move at the falling edge.
*/
`default_nettype none
module tb_pfa_async_fifo_host
	import pfa_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, host_wr, host_rd, bus_enable, tx_valid, tx_ready, rx_valid, rx_ready;
	logic [7:0] host_addr, host_wdata, host_rdata_q;
	logic interrupt_out_n, rx_crc_err;
	logic [15:0] node_id;
	logic [3:0] rx_ack;
	pfa_beat_s tx_beat, rx_beat;
	int err_total = 0;
	int samples_checked = 0;
	int n;
	logic [31:0] w, q[$];
	logic [15:0] legal = 16'h4AF7; // codes 0,1,2,4,5,6,7,9,B,E
	pfa_async_fifo_host dut_u (
		.clk(clk), .rst_n(rst_n), .host_addr(host_addr), .host_wdata(host_wdata),
		.host_wr(host_wr), .host_rd(host_rd), .host_rdata_q(host_rdata_q),
		.interrupt_out_n(interrupt_out_n), .bus_enable(bus_enable), .node_id(node_id),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_beat(tx_beat), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_beat(rx_beat), .rx_ack(rx_ack), .rx_crc_err(rx_crc_err)
	);
	pfa_link_model link_u (
		.clk(clk), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_beat(tx_beat),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_beat(rx_beat), .rx_ack(rx_ack),
		.rx_crc_err(rx_crc_err)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// host port tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		err_total += link_u.stuck;
		if (err_total == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// strobes are one cycle wide and two cycles apart
	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		@(negedge clk);
		host_wr = 1'b0;
	endtask
	task automatic rd8(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		host_addr = a;
		host_rd = 1'b1;
		@(negedge clk);
		host_rd = 1'b0;
		d = host_rdata_q;
	endtask
	// lane 3 completes a quadlet, and a lane 0 read pops, so go upward
	task automatic wrq(input logic [7:0] a, input logic [31:0] d);
		for (int i = 0; i < 4; i++) wr8(a + 8'(i), d[8*i +: 8]);
	endtask
	task automatic rdq(input logic [7:0] a, output logic [31:0] d);
		for (int i = 0; i < 4; i++) rd8(a + 8'(i), d[8*i +: 8]);
	endtask
	// status lags fifo events, so let it settle first
	task automatic chkr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		repeat (4) @(negedge clk);
		rdq(a, v);
		chk(v & m, e);
	endtask
	task automatic send_tx(input logic [31:0] d[$]);
		wrq(PFA_OFF_TX_FIRST, d[0]);
		for (int i = 1; i < d.size() - 1; i++) wrq(PFA_OFF_TX_MID, d[i]);
		wrq(PFA_OFF_TX_COMMIT, d[d.size() - 1]);
	endtask
	task automatic wait_tx(input int cnt);
		for (int k = 0; k < 600 && link_u.got.size() < cnt; k++) @(negedge clk);
		if (link_u.got.size() < cnt) begin
			err_total++;
			finish_test();
		end
	endtask
	// clear flags, flush, then a good packet must go out again
	task automatic recover();
		int c;
		wrq(PFA_OFF_IRQ_FLAGS, 32'h0006_0000);
		wrq(PFA_OFF_STATUS, 32'h0000_8000);
		c = link_u.got.size();
		send_tx('{32'h0000_0010, 32'h0000_0001});
		wait_tx(c + 2);
		chkr(PFA_OFF_IRQ_FLAGS, 32'h0006_0000, 32'h0);
	endtask
	// read quadlets until the empty flag rises; last word kept
	task automatic drain(output int cnt, output logic [31:0] d);
		logic [31:0] s;
		for (cnt = 0; cnt < 60; cnt++) begin
			repeat (4) @(negedge clk);
			rdq(PFA_OFF_STATUS, s);
			if (s[PFA_BIT_RX_EMPTY])
				break;
			rdq(PFA_OFF_TX_MID, d);
		end
		// an empty flag that never rises is a hang, not a pass
		if (cnt == 60) begin
			err_total++;
			finish_test();
		end
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		host_addr = 8'h00;
		host_wdata = 8'h00;
		host_wr = 1'b0;
		host_rd = 1'b0;
		bus_enable = 1'b1;
		node_id = 16'hFFC2;
		rst_n = 1'b0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		// reset values, and an unmapped place reads zero
		chkr(PFA_OFF_IRQ_FLAGS, 32'hFFFF_FFFF, 32'h0);
		chkr(PFA_OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h0);
		chkr(PFA_OFF_STATUS, 32'hFCF8_0000, 32'h0428_0000);
		wrq(8'h40, 32'hFFFF_FFFF);
		chkr(8'h40, 32'hFFFF_FFFF, 32'h0);
		// a packet sends itself, in order, through a stalling link
		link_u.slow = 1'b1;
		q = '{32'h0000_0000, 32'hFFC2_FFFF, 32'hF000_0400, 32'h1234_5678};
		send_tx(q);
		wait_tx(4);
		foreach (q[i])
			chk({link_u.got[i].first, link_u.got[i].last, link_u.got[i].data},
				{i == 0, i == 3, q[i]});
		// every code; a bad one blocks even a good packet behind it
		for (int tc = 0; tc < 16; tc++) begin
			n = link_u.got.size();
			send_tx('{{24'h0, 4'(tc), 4'h0}, 32'hA5A5_0000});
			repeat (30) @(negedge clk);
			chk(link_u.got.size() - n, legal[tc] ? 2 : 0);
			chkr(PFA_OFF_IRQ_FLAGS, 32'h0006_0000, legal[tc] ? 32'h0 : 32'h0002_0000);
			if (!legal[tc]) begin
				send_tx('{32'h0000_0010, 32'h0000_0002});
				repeat (30) @(negedge clk);
				chk(link_u.got.size() - n, 0);
				recover();
			end
		end
		// start quadlet through the middle port, then the commit port
		wrq(PFA_OFF_TX_MID, 32'h0000_0010);
		chkr(PFA_OFF_IRQ_FLAGS, 32'h0006_0000, 32'h0004_0000);
		recover();
		wrq(PFA_OFF_TX_COMMIT, 32'h0000_0010);
		chkr(PFA_OFF_IRQ_FLAGS, 32'h0006_0000, 32'h0004_0000);
		recover();
		// fill the transmit fifo with the bus off; further writes vanish
		bus_enable = 1'b0;
		link_u.got.delete();
		q.delete();
		for (int i = 0; i < PFA_TX_DEPTH; i++) q.push_back(32'h0000_0010 + i);
		send_tx(q);
		chkr(PFA_OFF_STATUS, 32'h0080_0000, 32'h0080_0000);
		wrq(PFA_OFF_TX_FIRST, 32'h0000_0010);
		repeat (20) @(negedge clk);
		chk(link_u.got.size(), 0);
		bus_enable = 1'b1;
		wait_tx(PFA_TX_DEPTH);
		repeat (40) @(negedge clk);
		chk(link_u.got.size(), PFA_TX_DEPTH);
		chk({link_u.got[PFA_TX_DEPTH-1].last, link_u.got[PFA_TX_DEPTH-1].data},
			{1'b1, q[PFA_TX_DEPTH-1]});
		recover();
		// receive with the flag unmasked, read back to back, then empty
		wrq(PFA_OFF_IRQ_MASK, 32'h0200_0000);
		link_u.send('{32'hFFC2_0010, 32'hFFC1_FFFF, 32'hF000_0220}, 4'h1, 1'b0);
		chkr(PFA_OFF_IRQ_FLAGS, 32'h0200_0000, 32'h0200_0000);
		chk(interrupt_out_n, 0);
		chkr(PFA_OFF_STATUS, 32'hFC00_0000, 32'h3000_0000);
		rdq(PFA_OFF_TX_MID, w);
		chk(w, 32'hFFC2_0010);
		rdq(PFA_OFF_TX_MID, w);
		chk(w, 32'hFFC1_FFFF);
		rdq(PFA_OFF_TX_MID, w);
		chk(w, 32'hF000_0220);
		chkr(PFA_OFF_STATUS, 32'hFC00_0000, 32'h0800_0000);
		rdq(PFA_OFF_TX_MID, w);
		chk(w, 32'h0000_0001);
		chkr(PFA_OFF_STATUS, 32'hFC00_0000, 32'h0400_0000);
		rdq(PFA_OFF_TX_MID, w);
		chk(w, 32'h0000_0001);
		wrq(PFA_OFF_IRQ_FLAGS, 32'h0200_0000);
		chkr(PFA_OFF_IRQ_FLAGS, 32'h0200_0000, 32'h0);
		chk(interrupt_out_n, 1);
		// foreign node dropped, broadcast kept, bad crc marked; masked
		wrq(PFA_OFF_IRQ_MASK, 32'h0);
		for (int k = 0; k < 3; k++) begin
			link_u.send('{{k == 0 ? 16'hFFC5 : k == 1 ? 16'hFFFF : 16'hFFC2, 16'h0010},
				32'h0000_0001, 32'hCAFE_0000}, 4'h2, k == 2);
			drain(n, w);
			chk(n, k == 0 ? 0 : 4);
			if (k != 0)
				chk(w, {28'h0, k == 1 ? 4'h2 : PFA_ACK_DATA_ERR});
		end
		chk(interrupt_out_n, 1);
		wrq(PFA_OFF_IRQ_FLAGS, 32'h0200_0000);
		// a packet longer than the receive fifo ends in the overflow ack
		q.delete();
		q.push_back(32'hFFC2_0010);
		for (int i = 0; i < 44; i++) q.push_back(i);
		link_u.send(q, 4'h1, 1'b0);
		chkr(PFA_OFF_STATUS, 32'hFC00_0000, 32'hB000_0000);
		drain(n, w);
		chk(w, {28'h0, PFA_ACK_OVERFLOW});
		chk(n <= PFA_RX_DEPTH, 1);
		finish_test();
	end
endmodule
`default_nettype wire
